// ### chan_regs_pkg.sv
// constants and types for the channel offset and status registers
package chan_regs_pkg;
   localparam logic [7:0] OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR = 8'h50;
   localparam logic [7:0] CH0_UOFS_LO_ADDR = 8'h55;
   localparam logic [7:0] CH0_UOFS_HI_ADDR = 8'h56;
   localparam logic [7:0] CH1_UOFS_LO_ADDR = 8'h5d;
   localparam logic [7:0] CH1_UOFS_HI_ADDR = 8'h5e;
   localparam logic [7:0] CH0_STATUS_ADDR = 8'h60;
   localparam logic [7:0] CH1_STATUS_ADDR = 8'h70;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CH0_FINAL_BIT = 7;
   localparam int CH1_FINAL_BIT = 6;
   localparam int CLIP_BIT = 7;
   localparam int PHASE_LSB = 4;
   localparam int INCMPLT_BIT = 3;
   localparam int ACTIVE_BIT = 2;
   localparam int OFSERR_BIT = 1;
   localparam int STFAIL_BIT = 0;
   localparam logic [2:0] PHASE_5 = 3'h5;
   localparam logic [2:0] PHASE_6 = 3'h6;
   localparam logic [2:0] PHASE_NA = 3'h7;
   typedef enum logic [1:0] {MODE_DSI3, MODE_SPI, MODE_I2C, MODE_PSI5} comm_mode_t;
endpackage : chan_regs_pkg

// ### channel_offset_status_regs.sv
// per-channel final phase select, user offset and status registers
`timescale 1ns/1ps
// Overview of operation
// RULE1: final select 0 ends cancellation at phase 6, 1 at phase 5 with no rate limit
// RULE2: each channel keeps a 16-bit signed user offset in low and high bytes
// RULE3: offset bytes accept writes until the init lock bit is set
// RULE4: offset is added to scaled data before the offset cancellation stage
// RULE5: one offset count moves the reported value by exactly one count
// RULE6: offset bytes take part in the read/write array check
// RULE7: host keeps offset small enough to avoid compression or railing
// RULE8: status registers read-only, reset zero except the self-test incomplete bit, fixed bit layout
// RULE9: clip flag sets when the sinc output hits max or min, non-PSI5 modes
// RULE10: clip flag clears on status read or on a transmission reporting it
// RULE11: in PSI5 mode the clip flag does not act on the device
// RULE12: phase field reports phase 0..6, code 7 unused
// RULE13: offset filter cutoff follows the phase, dividing by four each step
// RULE14: self-test incomplete sets at reset, clears on test enable or PSI5 test start
// RULE15: self-test active is OR of control bits 3..0 and transducer test voltage
// RULE16: offset error sets at limit, clears on read or report, PSI5 may keep it
// RULE17: self-test fail sets on PSI5 startup failure, only reset clears it
module channel_offset_status_regs
   import chan_regs_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire comm_mode_t comm_mode,
   input wire logic init_done_lock,
   input wire logic [3:0] selftest_control,
   input wire logic psi5_selftest_start,
   input wire logic psi5_selftest_fail,
   input wire logic [1:0] st_voltage_applied,
   input wire logic [1:0] sinc_at_limit,
   input wire logic [1:0] offset_limit_hit,
   input wire logic [1:0] clip_reported,
   input wire logic [1:0] ofserr_reported,
   input wire logic psi5_ofserr_hold,
   input wire logic [1:0] phase_step,
   input wire logic [2*DATA_W-1:0] scaled_data,
   output logic [7:0] reg_rdata,
   output logic [2*DATA_W-1:0] corrected_data,
   output logic [1:0] rate_limit_bypass,
   output logic [1:0] clip_to_device,
   output logic [1:0] final_phase_sel,
   output logic [5:0] cancel_phase_out,
   output logic [7:0] rw_array_checksum
);
   logic [7:0] phase_cfg_reg, phase_cfg_next;
   logic [15:0] uofs_reg [2];
   logic [15:0] uofs_next [2];
   logic [2:0] phase_reg [2];
   logic [2:0] phase_next [2];
   logic [1:0] clip_reg, clip_next, ofserr_reg, ofserr_next;
   logic incmplt_reg, incmplt_next, stfail_reg, stfail_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [2*DATA_W-1:0] data_reg, data_next;
   logic [1:0] bypass_reg, bypass_next, clipout_reg, clipout_next;
   logic [7:0] sum_reg, sum_next;
   logic [7:0] stat_val [2];
   logic [1:0] stat_rd;
   logic st_any;
   logic psi5;

   assign psi5 = (comm_mode == MODE_PSI5);
   assign st_any = |selftest_control;

   // register writes and offset bytes
   always_comb begin
      phase_cfg_next = phase_cfg_reg;
      uofs_next[0] = uofs_reg[0];
      uofs_next[1] = uofs_reg[1];
      if (reg_wr) begin
         if (reg_addr == OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR) begin
            phase_cfg_next = {reg_wdata[7:6], 6'h00};
         end
         if (!init_done_lock) begin // [RULE3]
            case (reg_addr)
               CH0_UOFS_LO_ADDR: uofs_next[0][7:0] = reg_wdata; // [RULE2]
               CH0_UOFS_HI_ADDR: uofs_next[0][15:8] = reg_wdata;
               CH1_UOFS_LO_ADDR: uofs_next[1][7:0] = reg_wdata;
               CH1_UOFS_HI_ADDR: uofs_next[1][15:8] = reg_wdata;
               default: uofs_next[0] = uofs_reg[0];
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_cfg_reg <= REG_RESET;
         uofs_reg[0] <= 16'h0000;
         uofs_reg[1] <= 16'h0000;
      end else begin
         phase_cfg_reg <= phase_cfg_next;
         uofs_reg[0] <= uofs_next[0];
         uofs_reg[1] <= uofs_next[1];
      end
   end

   assign final_phase_sel = {phase_cfg_reg[CH1_FINAL_BIT], phase_cfg_reg[CH0_FINAL_BIT]};
   assign stat_rd[0] = reg_rd && (reg_addr == CH0_STATUS_ADDR);
   assign stat_rd[1] = reg_rd && (reg_addr == CH1_STATUS_ADDR);

   // per-channel status and datapath
   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         logic [2:0] limit;
         // phase advance is supplied externally; the last phase is clamped here
         assign limit = final_phase_sel[c] ? PHASE_5 : PHASE_6; // [RULE1]
         always_comb begin
            phase_next[c] = phase_reg[c];
            if (phase_step[c] && phase_reg[c] < limit) begin
               phase_next[c] = 3'(phase_reg[c] + 3'h1); // [RULE12] [RULE13]
            end
            if (phase_reg[c] > limit) begin
               phase_next[c] = limit;
            end
            // set wins over a clear in the same cycle
            clip_next[c] = clip_reg[c];
            if (stat_rd[c] || clip_reported[c]) begin
               clip_next[c] = 1'b0; // [RULE10]
            end
            if (sinc_at_limit[c] && !psi5) begin
               clip_next[c] = 1'b1; // [RULE9]
            end
            ofserr_next[c] = ofserr_reg[c];
            if ((stat_rd[c] || ofserr_reported[c]) && !(psi5 && psi5_ofserr_hold)) begin
               ofserr_next[c] = 1'b0; // [RULE16]
            end
            if (offset_limit_hit[c]) begin
               ofserr_next[c] = 1'b1; // [RULE16]
            end
            // offset added before cancellation, same lsb weight
            data_next[c*DATA_W +: DATA_W] = DATA_W'(scaled_data[c*DATA_W +: DATA_W]
               + DATA_W'(signed'(uofs_reg[c]))); // [RULE4] [RULE5]
            bypass_next[c] = final_phase_sel[c] && (phase_reg[c] == PHASE_5); // [RULE1]
            clipout_next[c] = clip_reg[c] && !psi5; // [RULE11]
         end
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               phase_reg[c] <= 3'h0;
               clip_reg[c] <= 1'b0;
               ofserr_reg[c] <= 1'b0;
               data_reg[c*DATA_W +: DATA_W] <= '0;
               bypass_reg[c] <= 1'b0;
               clipout_reg[c] <= 1'b0;
            end else begin
               phase_reg[c] <= phase_next[c];
               clip_reg[c] <= clip_next[c];
               ofserr_reg[c] <= ofserr_next[c];
               data_reg[c*DATA_W +: DATA_W] <= data_next[c*DATA_W +: DATA_W];
               bypass_reg[c] <= bypass_next[c];
               clipout_reg[c] <= clipout_next[c];
            end
         end
         assign stat_val[c] = {clip_reg[c], phase_reg[c], incmplt_reg,
            st_any | st_voltage_applied[c], ofserr_reg[c], stfail_reg}; // [RULE8] [RULE15]
         assign cancel_phase_out[c*3 +: 3] = phase_reg[c];
         chk_clip_sets: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
            sinc_at_limit[c] && !psi5 |=> clip_reg[c])
            else $error("clip not set");
         chk_clip_clears: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
            stat_rd[c] && !sinc_at_limit[c] |=> !clip_reg[c])
            else $error("clip kept");
         chk_clip_psi5: assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
            psi5 |=> !clip_to_device[c])
            else $error("clip reached device in psi5");
         chk_phase_limit: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
            phase_reg[c] != PHASE_NA)
            else $error("phase code 7");
         chk_phase_step: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
            phase_step[c] && phase_reg[c] < PHASE_5
            |=> phase_reg[c] == 3'($past(phase_reg[c]) + 3'h1))
            else $error("phase not advanced");
         chk_phase_final: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
            final_phase_sel[c] && $stable(final_phase_sel[c]) |-> ##1 phase_reg[c] <= PHASE_5)
            else $error("phase beyond 5");
         chk_phase_clamp: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
            phase_reg[c] > limit |=> phase_reg[c] == $past(limit))
            else $error("phase not clamped");
         chk_bypass_set: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
            final_phase_sel[c] && phase_reg[c] == PHASE_5 |=> rate_limit_bypass[c])
            else $error("rate limit not bypassed");
         chk_ofs_add: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4] [RULE5]
            $stable(uofs_reg[c]) |=> data_reg[c*DATA_W +: DATA_W] == DATA_W'(
            $past(scaled_data[c*DATA_W +: DATA_W]) + DATA_W'(signed'($past(uofs_reg[c])))))
            else $error("offset sum wrong");
         chk_ofserr_sets: assert property (@(posedge ref_clk) disable iff (rst) // [RULE16]
            offset_limit_hit[c] |=> ofserr_reg[c])
            else $error("offset err lost");
         chk_ofserr_clear: assert property (@(posedge ref_clk) disable iff (rst) // [RULE16]
            stat_rd[c] && !offset_limit_hit[c] && !psi5 |=> !ofserr_reg[c])
            else $error("offset err kept after read");
         chk_ofserr_hold: assert property (@(posedge ref_clk) disable iff (rst) // [RULE16]
            psi5 && psi5_ofserr_hold && ofserr_reg[c] |=> ofserr_reg[c])
            else $error("offset err cleared in hold");
         chk_active_read: assert property (@(posedge ref_clk) disable iff (rst) // [RULE15]
            stat_rd[c] |=> reg_rdata[ACTIVE_BIT] == $past(|selftest_control | st_voltage_applied[c]))
            else $error("active flag wrong");
         chk_status_read: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
            stat_rd[c] |=> reg_rdata[CLIP_BIT] == $past(clip_reg[c])
            && reg_rdata[PHASE_LSB +: 3] == $past(phase_reg[c])
            && reg_rdata[OFSERR_BIT] == $past(ofserr_reg[c])
            && reg_rdata[STFAIL_BIT] == $past(stfail_reg))
            else $error("status read wrong");
      end
   endgenerate

   // self-test sticky flags
   always_comb begin
      incmplt_next = incmplt_reg;
      if (selftest_control[3] || selftest_control[2] || selftest_control[0]
         || psi5_selftest_start) begin
         incmplt_next = 1'b0; // [RULE14]
      end
      stfail_next = stfail_reg | psi5_selftest_fail; // [RULE17]
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         incmplt_reg <= 1'b1;
         stfail_reg <= 1'b0;
      end else begin
         incmplt_reg <= incmplt_next;
         stfail_reg <= stfail_next;
      end
   end

   // read mux and simple checksum over the writable array
   always_comb begin
      case (reg_addr)
         OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR: rdata_next = phase_cfg_reg;
         CH0_UOFS_LO_ADDR: rdata_next = uofs_reg[0][7:0];
         CH0_UOFS_HI_ADDR: rdata_next = uofs_reg[0][15:8];
         CH1_UOFS_LO_ADDR: rdata_next = uofs_reg[1][7:0];
         CH1_UOFS_HI_ADDR: rdata_next = uofs_reg[1][15:8];
         CH0_STATUS_ADDR: rdata_next = stat_val[0]; // [RULE8]
         CH1_STATUS_ADDR: rdata_next = stat_val[1];
         default: rdata_next = 8'h00;
      endcase
      if (!reg_rd) begin
         rdata_next = rdata_reg;
      end
      // xor check is cheap; it detects single flips, not every multi-bit upset
      sum_next = phase_cfg_reg ^ uofs_reg[0][7:0] ^ uofs_reg[0][15:8]
         ^ uofs_reg[1][7:0] ^ uofs_reg[1][15:8]; // [RULE6]
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         sum_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
         sum_reg <= sum_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign corrected_data = data_reg;
   assign rate_limit_bypass = bypass_reg;
   assign clip_to_device = clipout_reg;
   assign rw_array_checksum = sum_reg;

   chk_lock_holds: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
      init_done_lock |=> $stable(uofs_reg[0]) && $stable(uofs_reg[1]))
      else $error("offset written while locked");
   chk_write_lands: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2] [RULE3]
      reg_wr && !init_done_lock && reg_addr == CH1_UOFS_HI_ADDR
      |=> uofs_reg[1][15:8] == $past(reg_wdata))
      else $error("offset high byte not written");
   chk_lo_write: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2] [RULE3]
      reg_wr && !init_done_lock && reg_addr == CH0_UOFS_LO_ADDR
      |=> uofs_reg[0][7:0] == $past(reg_wdata))
      else $error("offset low byte not written");
   chk_cfg_write: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
      reg_wr && reg_addr == OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR
      |=> final_phase_sel == {$past(reg_wdata[CH1_FINAL_BIT]),
      $past(reg_wdata[CH0_FINAL_BIT])})
      else $error("final phase select not written");
   chk_checksum: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
      $stable(phase_cfg_reg) && $stable(uofs_reg[0]) && $stable(uofs_reg[1])
      |=> $stable(rw_array_checksum))
      else $error("checksum moved without a write");
   chk_rdata_holds: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   chk_incmplt_clr: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
      psi5_selftest_start |=> !incmplt_reg)
      else $error("incomplete kept");
   chk_incmplt_ctrl: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
      selftest_control[3] || selftest_control[2] || selftest_control[0] |=> !incmplt_reg)
      else $error("incomplete kept after test enable");
   chk_fail_sets: assert property (@(posedge ref_clk) disable iff (rst) // [RULE17]
      psi5_selftest_fail |=> stfail_reg)
      else $error("self-test fail lost");
   chk_fail_sticky: assert property (@(posedge ref_clk) disable iff (rst) // [RULE17]
      stfail_reg |=> stfail_reg)
      else $error("self-test fail cleared");
   chk_reset_vals: assert property (@(posedge ref_clk) // [RULE8] [RULE14]
      $fell(rst) |-> incmplt_reg && !stfail_reg && clip_reg == 2'b00 && ofserr_reg == 2'b00
      && phase_reg[0] == 3'h0 && phase_reg[1] == 3'h0)
      else $error("status not at reset value");
endmodule : channel_offset_status_regs

// ### tb_channel_offset_status_regs.sv
// self-checking bench for the channel offset and status registers
`timescale 1ns/1ps
module tb_channel_offset_status_regs;
   import chan_regs_pkg::*;
   logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, init_done_lock = 0;
   logic psi5_selftest_start = 0, psi5_selftest_fail = 0, psi5_ofserr_hold = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rw_array_checksum, cfg = 0;
   logic [3:0] selftest_control = 0;
   logic [1:0] st_voltage_applied = 0, sinc_at_limit = 0, offset_limit_hit = 0;
   logic [1:0] clip_reported = 0, ofserr_reported = 0, phase_step = 0;
   logic [1:0] rate_limit_bypass, clip_to_device, final_phase_sel;
   logic [5:0] cancel_phase_out;
   logic [31:0] scaled_data = 0, corrected_data, seed = 32'h1;
   comm_mode_t comm_mode = MODE_SPI;
   int bad_count = 0, check_count = 0;
   logic [7:0] ofs[4];
   logic [7:0] oaddr[4] = '{CH0_UOFS_LO_ADDR, CH0_UOFS_HI_ADDR,
      CH1_UOFS_LO_ADDR, CH1_UOFS_HI_ADDR};
   channel_offset_status_regs dut_u (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .comm_mode, .init_done_lock, .selftest_control, .psi5_selftest_start, .psi5_selftest_fail,
      .st_voltage_applied, .sinc_at_limit, .offset_limit_hit, .clip_reported, .ofserr_reported,
      .psi5_ofserr_hold, .phase_step, .scaled_data, .reg_rdata,
      .corrected_data, .rate_limit_bypass, .clip_to_device, .final_phase_sel,
      .cancel_phase_out, .rw_array_checksum);
   always #12.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   // strobe held for one edge, then one idle edge so strobes never merge
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = wr;
      reg_rd = !wr;
      tick();
      reg_wr = 0;
      reg_rd = 0;
      tick();
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(0, a, 8'h00);
      chk("reg_rdata", exp, reg_rdata);
   endtask : rd
   task automatic done_t(input string s);
      $display("test %s ends, checks %0d, mismatches %0d", s, check_count, bad_count);
   endtask : done_t
   function automatic logic [7:0] csum();
      return cfg ^ ofs[0] ^ ofs[1] ^ ofs[2] ^ ofs[3];
   endfunction : csum
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 rst = 0;
      rd(CH0_STATUS_ADDR, 8'h08);
      rd(CH1_STATUS_ADDR, 8'h08);
      rd(8'h57, 8'h00);
      rd(OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR, 8'h00);
      done_t("reset");
      for (int n = 0; n < 4; n++) begin
         for (int i = 0; i < 4; i++) begin
            // high bytes only extend the sign: offset stays well inside full scale
            ofs[i] = i[0] ? {8{ofs[i-1][7]}} : 8'(xs());
            acc(1, oaddr[i], ofs[i]);
         end
         scaled_data = xs();
         tick();
         for (int i = 0; i < 4; i++) rd(oaddr[i], ofs[i]);
         chk("corrected_data", {16'({ofs[3], ofs[2]} + scaled_data[31:16]),
            16'({ofs[1], ofs[0]} + scaled_data[15:0])}, corrected_data);
         chk("rw_array_checksum", csum(), rw_array_checksum);
      end
      done_t("offset");
      init_done_lock = 1;
      for (int i = 0; i < 4; i++) acc(1, oaddr[i], ~ofs[i]);
      for (int i = 0; i < 4; i++) rd(oaddr[i], ofs[i]);
      chk("rw_array_checksum", csum(), rw_array_checksum);
      init_done_lock = 0;
      done_t("lock");
      cfg = 8'h80;
      acc(1, OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR, cfg);
      acc(1, CH0_STATUS_ADDR, 8'hff);
      rd(OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR, cfg);
      chk("final_phase_sel", 2'b01, final_phase_sel);
      // more steps than phases, so both channels sit at their clamp
      for (int i = 0; i < 8; i++) begin
         phase_step = 2'b11;
         tick();
         phase_step = 2'b00;
         tick();
      end
      rd(CH0_STATUS_ADDR, 8'h58);
      rd(CH1_STATUS_ADDR, 8'h68);
      chk("rate_limit_bypass", 2'b01, rate_limit_bypass);
      chk("cancel_phase_out", {PHASE_6, PHASE_5}, cancel_phase_out);
      chk("rw_array_checksum", csum(), rw_array_checksum);
      done_t("phase");
      sinc_at_limit = 2'b11;
      tick();
      sinc_at_limit = 2'b00;
      clip_reported = 2'b10;
      tick();
      clip_reported = 2'b00;
      tick();
      chk("clip_to_device", 2'b01, clip_to_device);
      rd(CH0_STATUS_ADDR, 8'hd8);
      rd(CH0_STATUS_ADDR, 8'h58);
      rd(CH1_STATUS_ADDR, 8'h68);
      comm_mode = MODE_PSI5;
      sinc_at_limit = 2'b11;
      tick();
      sinc_at_limit = 2'b00;
      tick();
      chk("clip_to_device", 2'b00, clip_to_device);
      rd(CH0_STATUS_ADDR, 8'h58);
      comm_mode = MODE_I2C;
      done_t("clip");
      offset_limit_hit = 2'b11;
      tick();
      offset_limit_hit = 2'b00;
      ofserr_reported = 2'b01;
      tick();
      ofserr_reported = 2'b00;
      rd(CH0_STATUS_ADDR, 8'h58);
      rd(CH1_STATUS_ADDR, 8'h6a);
      rd(CH1_STATUS_ADDR, 8'h68);
      comm_mode = MODE_PSI5;
      psi5_ofserr_hold = 1;
      offset_limit_hit = 2'b10;
      tick();
      offset_limit_hit = 2'b00;
      rd(CH1_STATUS_ADDR, 8'h6a);
      rd(CH1_STATUS_ADDR, 8'h6a);
      done_t("offset error");
      selftest_control = 4'b0010;
      rd(CH0_STATUS_ADDR, 8'h5c);
      selftest_control = 4'b0000;
      st_voltage_applied = 2'b01;
      rd(CH0_STATUS_ADDR, 8'h5c);
      st_voltage_applied = 2'b00;
      selftest_control = 4'b0001;
      tick();
      rd(CH0_STATUS_ADDR, 8'h54);
      selftest_control = 4'b0000;
      rd(CH0_STATUS_ADDR, 8'h50);
      psi5_selftest_fail = 1;
      tick();
      psi5_selftest_fail = 0;
      rd(CH0_STATUS_ADDR, 8'h51);
      rd(CH0_STATUS_ADDR, 8'h51);
      cfg = 8'hc0;
      acc(1, OFFSET_CANCEL_FINAL_PHASE_CFG_ADDR, cfg);
      rd(CH1_STATUS_ADDR, 8'h53);
      chk("rate_limit_bypass", 2'b11, rate_limit_bypass);
      done_t("self-test");
      comm_mode = MODE_DSI3;
      psi5_ofserr_hold = 0;
      rst = 1;
      repeat (2) tick();
      rst = 0;
      rd(CH0_STATUS_ADDR, 8'h08);
      rd(CH0_UOFS_HI_ADDR, 8'h00);
      psi5_selftest_start = 1;
      tick();
      psi5_selftest_start = 0;
      sinc_at_limit = 2'b01;
      tick();
      sinc_at_limit = 2'b00;
      rd(CH0_STATUS_ADDR, 8'h80);
      rd(CH0_STATUS_ADDR, 8'h00);
      done_t("second reset");
      close_out();
   end
endmodule : tb_channel_offset_status_regs
